// ===== core/bcf_bus_flags.sv
// bus condition flags, bus busy state and start request handling
// Summary of operation
// - a detected start sets start_seen_flag, marking the address period
// - start_seen_flag clears on stop, next byte clock, leave, disable, reset
// - a detected stop sets stop_seen_flag
// - stop_seen_flag clears at first address clock after a later start
// - stop_seen_flag also clears on wake bit fall, disable, reset
// - bit operation on another bus_status bit clears arbitration_lost_flag
// - stretch release at ninth clock clears transmit state, releases data line
// - bus_flags: bit7 start cleared, bit6 busy, bit1 initial start, bit0 reservation
// - bus_flags reads valid only while the controller is enabled
// - reset clears bus_flags to zero
// - refused start with reservation on clears request, sets cleared flag
// - cleared flag drops on start request write, disable, reset
// - busy sets on start or enable without initial start; clears on stop
// - start allowed only on released bus, which initial start forces
// - a detected start clears initial_start_enable
`timescale 1ns/1ps
`default_nettype none
module bcf_bus_flags import bcf_pkg::*; (
	input  wire logic      core_clk,      // system clock
	input  wire logic      reset_n,       // asynchronous reset, active low
	input  wire logic      link_clk,      // bus sampling clock
	input  wire logic      scl_in,        // serial_clock_pin level
	input  wire logic      sda_in,        // serial_data_pin level
	output logic           sda_out,       // serial_data_pin drive value
	output logic           sda_oe_n,      // serial_data_pin enable, low drives
	input  wire bcf_addr_t cpu_addr,      // cpu address
	input  wire logic      cpu_wr,        // byte write strobe
	input  wire logic      cpu_bit_wr,    // single-bit write strobe
	input  wire logic [2:0] cpu_bit_idx,  // bit number for single-bit write
	input  wire bcf_byte_t cpu_wdata,     // write data, bit writes use bit 0
	input  wire logic      cpu_rd,        // read strobe
	output bcf_byte_t      cpu_rdata,     // read data, one cycle after strobe
	input  wire logic      arb_lost_in,   // arbitration lost pulse
	input  wire logic      tx_bit_in,     // transmit data bit from the shifter
	output logic           start_gen_req  // pulse asking to generate a start
);
	bcf_evt_if evif ();

	bcf_link_watch u_watch (
		.link_clk (link_clk),
		.reset_n  (reset_n),
		.scl_in   (scl_in),
		.sda_in   (sda_in),
		.ev       (evif.link)
	);

	bcf_evt_sync u_sync (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.ev       (evif.sync)
	);

	// merge a byte write or a single-bit write into the old value
	function automatic bcf_byte_t bcf_merge(input bcf_byte_t old, input logic byte_wr,
			input logic [2:0] idx, input bcf_byte_t d);
		bcf_byte_t r;
		r = old;
		if (byte_wr) begin
			r = d;
		end else begin
			r[idx] = d[0];
		end
		return r;
	endfunction

	// a command bit counts only when this access really wrote it
	function automatic logic bcf_cmd(input bcf_byte_t m, input int pos, input logic byte_wr,
			input logic [2:0] idx);
		return m[pos] && (byte_wr || (idx == 3'(pos)));
	endfunction

	logic       en_reg, en_next, stt_reg, stt_next, stcf_reg, stcf_next;
	logic       bsy_reg, bsy_next, stcen_reg, stcen_next, rsv_reg, rsv_next;
	logic       wup_reg, wup_next, std_reg, std_next, spd_reg, spd_next;
	logic       trc_reg, trc_next, ald_reg, ald_next, sgen_reg, sgen_next;
	logic       sda_out_reg, sda_out_next, oe_n_reg, oe_n_next;
	bcf_phase_t phase_reg, phase_next;
	bcf_cnt_t   cnt_reg, cnt_next;
	bcf_byte_t  rdata_reg, rdata_next;
	bcf_byte_t  flags_cur, sts_cur, ctl_cur, ctl1_cur, mf, mc, m1;
	logic       any_wr, flags_wr, ctl_wr, ctl1_wr, sts_bitop;
	logic       lrel_cmd, wrel_cmd, stt_wr1, en_fall, en_rise, wup_fall;
	logic       ev_start, ev_stop, rise, rbit, first_addr_clk, next_byte_clk;

	// register views, decode and merged write values
	always_comb begin
		flags_cur            = BYTE_ZERO;
		flags_cur[FLG_STCF]  = stcf_reg;
		flags_cur[FLG_BSY]   = bsy_reg;
		flags_cur[FLG_STCEN] = stcen_reg;
		flags_cur[FLG_RSV]   = rsv_reg;
		sts_cur              = BYTE_ZERO;
		sts_cur[STS_ALD]     = ald_reg;
		sts_cur[STS_TRC]     = trc_reg;
		sts_cur[STS_STD]     = std_reg;
		sts_cur[STS_SPD]     = spd_reg;
		ctl_cur              = BYTE_ZERO;
		ctl_cur[CTL_EN]      = en_reg;
		ctl_cur[CTL_STT]     = stt_reg;
		ctl1_cur             = BYTE_ZERO;
		ctl1_cur[CTL1_WUP]   = wup_reg;
		any_wr    = cpu_wr || cpu_bit_wr;
		flags_wr  = any_wr && (cpu_addr == FLAGS_ADDR);
		ctl_wr    = any_wr && (cpu_addr == CTL0_ADDR);
		ctl1_wr   = any_wr && (cpu_addr == CTL1_ADDR);
		sts_bitop = cpu_bit_wr && (cpu_addr == STATUS_ADDR);
		mf = bcf_merge(flags_cur, cpu_wr, cpu_bit_idx, cpu_wdata);
		mc = bcf_merge(ctl_cur, cpu_wr, cpu_bit_idx, cpu_wdata);
		m1 = bcf_merge(ctl1_cur, cpu_wr, cpu_bit_idx, cpu_wdata);
		lrel_cmd = ctl_wr && bcf_cmd(mc, CTL_LREL, cpu_wr, cpu_bit_idx);
		wrel_cmd = ctl_wr && bcf_cmd(mc, CTL_WREL, cpu_wr, cpu_bit_idx);
		stt_wr1  = ctl_wr && bcf_cmd(mc, CTL_STT, cpu_wr, cpu_bit_idx);
		ev_start = evif.pulse[EV_START] && en_reg;
		ev_stop  = evif.pulse[EV_STOP] && en_reg;
		rise     = (evif.pulse[EV_RISE0] || evif.pulse[EV_RISE1]) && en_reg;
		rbit     = evif.pulse[EV_RISE1];
		first_addr_clk = rise && (phase_reg == PH_ADDR) && (cnt_reg == CNT_ZERO);
		next_byte_clk  = rise && (phase_reg == PH_ADDR) && (cnt_reg == CNT_ACK);
	end

	// next state of every flag, the byte phase and the pin drive
	always_comb begin
		en_next = ctl_wr ? mc[CTL_EN] : en_reg;
		wup_next = ctl1_wr ? m1[CTL1_WUP] : wup_reg;
		en_fall = en_reg && !en_next;
		en_rise = !en_reg && en_next;
		wup_fall = wup_reg && !wup_next;
		stcen_next = stcen_reg;
		rsv_next = rsv_reg;
		if (flags_wr && !en_reg) begin
			stcen_next = mf[FLG_STCEN];
			rsv_next   = mf[FLG_RSV];
		end
		if (ev_start) begin
			stcen_next = 1'b0;
		end
		// byte phase and clock count
		phase_next = phase_reg;
		cnt_next = cnt_reg;
		if (ev_start) begin
			phase_next = PH_ADDR;
			cnt_next = CNT_ZERO;
		end else if (ev_stop || lrel_cmd || en_fall) begin
			phase_next = PH_IDLE;
			cnt_next = CNT_ZERO;
		end else if (rise && (phase_reg != PH_IDLE)) begin
			if (cnt_reg == CNT_ACK) begin
				phase_next = PH_DATA;
				cnt_next = CNT_ONE;
			end else begin
				cnt_next = cnt_reg + CNT_ONE;
			end
		end
		// start seen
		std_next = std_reg;
		if (ev_stop || next_byte_clk || lrel_cmd) std_next = 1'b0;
		if (ev_start) std_next = 1'b1;
		// stop seen
		spd_next = spd_reg;
		if (first_addr_clk || wup_fall) spd_next = 1'b0;
		if (ev_stop) spd_next = 1'b1;
		// bus busy, initial value chosen by initial start enable
		bsy_next = bsy_reg;
		if (ev_stop) bsy_next = 1'b0;
		if (ev_start || (en_rise && !stcen_reg)) bsy_next = 1'b1;
		// arbitration lost
		ald_next = ald_reg;
		if (sts_bitop && (cpu_bit_idx != 3'(STS_ALD))) ald_next = 1'b0;
		if (arb_lost_in && en_reg) ald_next = 1'b1;
		// transmit state
		trc_next = trc_reg;
		if (rise && (phase_reg == PH_ADDR) && (cnt_reg == CNT_PRE_DIR) && rbit) begin
			trc_next = 1'b1;
		end
		if (trc_reg && wrel_cmd && (cnt_reg == CNT_ACK)) trc_next = 1'b0;
		if (ev_stop || lrel_cmd || (arb_lost_in && en_reg)) trc_next = 1'b0;
		// start request with optional reservation
		stt_next = ctl_wr ? mc[CTL_STT] : stt_reg;
		stcf_next = stcf_reg;
		sgen_next = 1'b0;
		if (stt_wr1) stcf_next = 1'b0;
		if (stt_reg && en_reg && !ctl_wr) begin
			if (!bsy_reg) begin
				sgen_next = 1'b1;
				stt_next = 1'b0;
			end else if (rsv_reg) begin
				stt_next = 1'b0;
				stcf_next = 1'b1;
			end
		end
		// disabling acts like a reset of the bus state
		if (en_fall) begin
			std_next = 1'b0;
			spd_next = 1'b0;
			trc_next = 1'b0;
			ald_next = 1'b0;
		end
		if (!en_next) begin
			bsy_next = 1'b0;
			stcf_next = 1'b0;
			stt_next = 1'b0;
			sgen_next = 1'b0;
		end
		// data line drive follows transmit state
		oe_n_next = !trc_next;
		sda_out_next = tx_bit_in;
		// read data
		rdata_next = rdata_reg;
		if (cpu_rd) begin
			if (cpu_addr == FLAGS_ADDR) begin
				rdata_next = en_reg ? flags_cur : BYTE_ZERO;
			end else if (cpu_addr == STATUS_ADDR) begin
				rdata_next = sts_cur;
			end else if (cpu_addr == CTL0_ADDR) begin
				rdata_next = ctl_cur;
			end else if (cpu_addr == CTL1_ADDR) begin
				rdata_next = ctl1_cur;
			end else begin
				rdata_next = BYTE_ZERO;
			end
		end
	end

	// state registers
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			en_reg      <= 1'b0;
			stt_reg     <= 1'b0;
			stcf_reg    <= 1'b0;
			bsy_reg     <= 1'b0;
			stcen_reg   <= 1'b0;
			rsv_reg     <= 1'b0;
			wup_reg     <= 1'b0;
			std_reg     <= 1'b0;
			spd_reg     <= 1'b0;
			trc_reg     <= 1'b0;
			ald_reg     <= 1'b0;
			sgen_reg    <= 1'b0;
			sda_out_reg <= 1'b1;
			oe_n_reg    <= 1'b1;
			phase_reg   <= PH_IDLE;
			cnt_reg     <= CNT_ZERO;
			rdata_reg   <= BYTE_ZERO;
		end else begin
			en_reg      <= en_next;
			stt_reg     <= stt_next;
			stcf_reg    <= stcf_next;
			bsy_reg     <= bsy_next;
			stcen_reg   <= stcen_next;
			rsv_reg     <= rsv_next;
			wup_reg     <= wup_next;
			std_reg     <= std_next;
			spd_reg     <= spd_next;
			trc_reg     <= trc_next;
			ald_reg     <= ald_next;
			sgen_reg    <= sgen_next;
			sda_out_reg <= sda_out_next;
			oe_n_reg    <= oe_n_next;
			phase_reg   <= phase_next;
			cnt_reg     <= cnt_next;
			rdata_reg   <= rdata_next;
		end
	end

	// outputs straight from flops
	assign sda_out       = sda_out_reg;
	assign sda_oe_n      = oe_n_reg;
	assign cpu_rdata     = rdata_reg;
	assign start_gen_req = sgen_reg;

	// checks on the flag behaviour
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	property p_start_sets_std;
		ev_start && en_next |=> std_reg && bsy_reg && !stcen_reg;
	endproperty
	a_start_sets_std: assert property (p_start_sets_std) else $error("start not flagged");
	property p_stop_clears_std;
		ev_stop && !ev_start && en_next |=> !std_reg && spd_reg && !bsy_reg;
	endproperty
	a_stop_clears_std: assert property (p_stop_clears_std) else $error("stop mishandled");
	property p_spd_first_clk;
		first_addr_clk && !ev_stop |=> !spd_reg;
	endproperty
	a_spd_first_clk: assert property (p_spd_first_clk) else $error("stop flag kept");
	property p_disable_clears;
		$fell(en_reg) |-> !std_reg && !spd_reg && !bsy_reg && !stcf_reg;
	endproperty
	a_disable_clears: assert property (p_disable_clears) else $error("disable left flags");
	property p_ald_clear;
		sts_bitop && cpu_bit_idx != 3'(STS_ALD) && !arb_lost_in |=> !ald_reg;
	endproperty
	a_ald_clear: assert property (p_ald_clear) else $error("arbitration flag kept");
	property p_wrel_release;
		trc_reg && wrel_cmd && cnt_reg == CNT_ACK |=> !trc_reg && sda_oe_n;
	endproperty
	a_wrel_release: assert property (p_wrel_release) else $error("data line not released");
	property p_flags_read;
		cpu_rd && cpu_addr == FLAGS_ADDR |=> cpu_rdata[5:2] == 4'h0 &&
			(cpu_rdata == BYTE_ZERO || $past(en_reg));
	endproperty
	a_flags_read: assert property (p_flags_read) else $error("bad flags read");
	property p_refuse_start;
		stt_reg && en_reg && bsy_reg && rsv_reg && !ctl_wr && en_next |=> stcf_reg && !stt_reg
			##1 !start_gen_req;
	endproperty
	a_refuse_start: assert property (p_refuse_start) else $error("refused start wrong");
	property p_busy_init;
		$rose(en_reg) && !$past(stcen_reg) |-> bsy_reg;
	endproperty
	a_busy_init: assert property (p_busy_init) else $error("busy not set at enable");
	property p_option_lock;
		en_reg && flags_wr && !ev_start |=> $stable(stcen_reg) && $stable(rsv_reg);
	endproperty
	a_option_lock: assert property (p_option_lock) else $error("option written while on");

	c_start_req: cover property (stt_reg && !bsy_reg && en_reg ##1 start_gen_req);
	c_byte_done: cover property (next_byte_clk);
	c_refused: cover property ($rose(stcf_reg));
	c_release: cover property ($fell(trc_reg) && sda_oe_n);
endmodule
`default_nettype wire

// ===== core/bcf_evt_if.sv
// bus event carrier between the link watcher, the synchroniser and the flag core
`timescale 1ns/1ps
`default_nettype none
interface bcf_evt_if;
	import bcf_pkg::*;
	logic [EV_N-1:0] tgl;   // toggles, link domain
	logic [EV_N-1:0] pulse; // one-cycle pulses, core domain

	modport link (output tgl);
	modport sync (input tgl, output pulse);
	modport core (input pulse);
endinterface
`default_nettype wire

// ===== core/bcf_evt_sync.sv
// core-domain toggle synchroniser turning each link event into one pulse
`timescale 1ns/1ps
`default_nettype none
module bcf_evt_sync import bcf_pkg::*; (
	input  wire logic core_clk, // core clock
	input  wire logic reset_n,  // asynchronous reset, active low
	bcf_evt_if.sync   ev        // toggles in, pulses out
);
	genvar g;
	generate
		for (g = 0; g < EV_N; g++) begin : g_ev
			logic s1_reg, s2_reg, s3_reg;
			// two flops, then an edge flop that only sees the second
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
				end else begin
					s1_reg <= ev.tgl[g];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
				end
			end
			assign ev.pulse[g] = s2_reg ^ s3_reg;
		end
	endgenerate
endmodule
`default_nettype wire

// ===== core/bcf_link_watch.sv
// link-domain watcher: samples the bus pins and toggles one line per bus event
`timescale 1ns/1ps
`default_nettype none
module bcf_link_watch import bcf_pkg::*; (
	input  wire logic link_clk, // bus sampling clock
	input  wire logic reset_n,  // asynchronous reset, active low
	input  wire logic scl_in,   // clock pin level
	input  wire logic sda_in,   // data pin level
	bcf_evt_if.link   ev        // event toggles
);
	logic            scl_m_reg, scl_s_reg, scl_p_reg;
	logic            sda_m_reg, sda_s_reg, sda_p_reg;
	logic [EV_N-1:0] tgl_reg, tgl_next;

	// start, stop and clock rises seen on synchronised samples
	always_comb begin
		tgl_next = tgl_reg;
		if (scl_s_reg && scl_p_reg && sda_p_reg && !sda_s_reg) begin
			tgl_next[EV_START] = !tgl_reg[EV_START];
		end
		if (scl_s_reg && scl_p_reg && !sda_p_reg && sda_s_reg) begin
			tgl_next[EV_STOP] = !tgl_reg[EV_STOP];
		end
		if (scl_s_reg && !scl_p_reg) begin
			if (sda_s_reg) begin
				tgl_next[EV_RISE1] = !tgl_reg[EV_RISE1];
			end else begin
				tgl_next[EV_RISE0] = !tgl_reg[EV_RISE0];
			end
		end
	end

	// two-flop pin synchronisers, history and toggles
	always_ff @(posedge link_clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_m_reg <= 1'b1;
			scl_s_reg <= 1'b1;
			scl_p_reg <= 1'b1;
			sda_m_reg <= 1'b1;
			sda_s_reg <= 1'b1;
			sda_p_reg <= 1'b1;
			tgl_reg   <= '0;
		end else begin
			scl_m_reg <= scl_in;
			scl_s_reg <= scl_m_reg;
			scl_p_reg <= scl_s_reg;
			sda_m_reg <= sda_in;
			sda_s_reg <= sda_m_reg;
			sda_p_reg <= sda_s_reg;
			tgl_reg   <= tgl_next;
		end
	end

	assign ev.tgl = tgl_reg;
endmodule
`default_nettype wire

// ===== core/bcf_pkg.sv
// shared constants and types of the bus condition flag block
package bcf_pkg;
	typedef logic [19:0] bcf_addr_t;
	typedef logic [7:0]  bcf_byte_t;
	typedef logic [3:0]  bcf_cnt_t;

	// register addresses
	localparam bcf_addr_t FLAGS_ADDR  = 20'hFFF52;
	localparam bcf_addr_t STATUS_ADDR = 20'hFFF51;
	localparam bcf_addr_t CTL0_ADDR   = 20'hF0230;
	localparam bcf_addr_t CTL1_ADDR   = 20'hF0231;
	localparam bcf_byte_t BYTE_ZERO   = 8'h00;

	// bus_flags fields
	localparam int FLG_STCF  = 7;
	localparam int FLG_BSY   = 6;
	localparam int FLG_STCEN = 1;
	localparam int FLG_RSV   = 0;
	// main_control_reg fields
	localparam int CTL_EN    = 7;
	localparam int CTL_LREL  = 6;
	localparam int CTL_WREL  = 5;
	localparam int CTL_STT   = 1;
	// wake control register field
	localparam int CTL1_WUP  = 7;
	// bus_status fields
	localparam int STS_ALD   = 4;
	localparam int STS_TRC   = 3;
	localparam int STS_STD   = 1;
	localparam int STS_SPD   = 0;

	// clock counts within a byte
	localparam bcf_cnt_t CNT_ZERO    = 4'h0;
	localparam bcf_cnt_t CNT_ONE     = 4'h1;
	localparam bcf_cnt_t CNT_PRE_DIR = 4'h7; // count just before the direction clock
	localparam bcf_cnt_t CNT_ACK     = 4'h9; // ninth clock of a byte

	// bus events carried from the link domain
	localparam int EV_START = 0;
	localparam int EV_STOP  = 1;
	localparam int EV_RISE0 = 2;
	localparam int EV_RISE1 = 3;
	localparam int EV_N     = 4;

	typedef enum logic [2:0] {
		PH_IDLE = 3'b001,
		PH_ADDR = 3'b010,
		PH_DATA = 3'b100
	} bcf_phase_t;
endpackage

// ===== sim/bcf_bus_model.sv
// open-drain bus master model driving the clock and data lines
`timescale 1ns/1ps
`default_nettype none
module bcf_bus_model #(
	parameter int PH = 640 // ns per bus phase, four link samples
) (
	output logic scl_low, // pulls clock line low
	output logic sda_low  // pulls data line low
);
	// both lines start released, pull-ups hold them high
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end

	// data falls while clock high, then clock goes low
	task automatic do_start();
		sda_low = 1'b0;
		#PH;
		scl_low = 1'b0;
		#PH;
		sda_low = 1'b1;
		#PH;
		scl_low = 1'b1;
		#PH;
	endtask

	// one clock pulse, data set up while the clock is low
	task automatic do_bit(input logic b);
		sda_low = ~b;
		#PH;
		scl_low = 1'b0;
		#PH;
		scl_low = 1'b1;
		#PH;
	endtask

	// data rises while clock high, bus left released
	task automatic do_stop();
		sda_low = 1'b1;
		#PH;
		scl_low = 1'b0;
		#PH;
		sda_low = 1'b0;
		#PH;
	endtask

	// address byte msb first, then an acknowledged ninth clock
	task automatic do_byte(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			do_bit(v[i]);
		end
		do_bit(1'b0);
	endtask
endmodule
`default_nettype wire

// ===== sim/test_bcf_bus_flags.sv
// self-checking bench of the bus condition flag block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
	total_checks++; \
	if ((got) !== (exp)) begin \
		num_errors++; \
		$display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
	end \
end
module test_bcf_bus_flags;
	import bcf_pkg::*;
	int         num_errors;
	int         total_checks;
	int         gen_cnt;
	logic       core_clk, link_clk, reset_n, scl_low, sda_low, scl_in, sda_in;
	logic       sda_out, sda_oe_n, cpu_wr, cpu_bit_wr, cpu_rd, arb_lost_in;
	logic       tx_bit_in, start_gen_req;
	logic [2:0] cpu_bit_idx;
	bcf_addr_t  cpu_addr;
	bcf_byte_t  cpu_wdata, cpu_rdata;

	// wired-and lines with pull-ups
	assign scl_in = ~scl_low;
	assign sda_in = ~(sda_low | (~sda_oe_n & ~sda_out));

	bcf_bus_model bm (.scl_low(scl_low), .sda_low(sda_low));

	bcf_bus_flags dut (
		.core_clk(core_clk), .reset_n(reset_n), .link_clk(link_clk),
		.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_bit_wr(cpu_bit_wr),
		.cpu_bit_idx(cpu_bit_idx), .cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd),
		.cpu_rdata(cpu_rdata), .arb_lost_in(arb_lost_in), .tx_bit_in(tx_bit_in),
		.start_gen_req(start_gen_req)
	);

	// clocks: core 5 ns, link 160 ns with an unrelated offset
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	initial begin
		link_clk = 1'b0;
		#37;
		forever #80 link_clk = ~link_clk;
	end

	// counts cycles in which a start is asked for, sampled mid-cycle where the pulse stands
	always @(negedge core_clk) begin
		if (start_gen_req === 1'b1) begin
			gen_cnt++;
		end
	end

	task automatic wr(input bcf_addr_t a, input bcf_byte_t d);
		@(posedge core_clk) #1;
		cpu_addr = a;
		cpu_wdata = d;
		cpu_wr = 1'b1;
		@(posedge core_clk) #1;
		cpu_wr = 1'b0;
	endtask

	task automatic bwr(input bcf_addr_t a, input logic [2:0] idx, input logic v);
		@(posedge core_clk) #1;
		cpu_addr = a;
		cpu_bit_idx = idx;
		cpu_wdata = {7'h00, v};
		cpu_bit_wr = 1'b1;
		@(posedge core_clk) #1;
		cpu_bit_wr = 1'b0;
	endtask

	// read data stands from the edge after the strobe
	task automatic rd(input bcf_addr_t a, input bcf_byte_t exp);
		@(posedge core_clk) #1;
		cpu_addr = a;
		cpu_rd = 1'b1;
		@(posedge core_clk) #1;
		cpu_rd = 1'b0;
		`CHK(cpu_rdata, exp)
	endtask

	// bus events need a few link and core cycles to reach the flags
	task automatic settle();
		repeat (8) @(posedge link_clk);
	endtask

	task automatic wait_gen(input int exp);
		repeat (30) @(posedge core_clk);
		`CHK(gen_cnt, exp)
	endtask

	task automatic done(input string name);
		$display("test %s done", name);
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// watchdog against a hang
	initial begin
		#400000;
		num_errors++;
		end_sim();
	end

	// main sequence
	initial begin
		num_errors = 0;
		total_checks = 0;
		gen_cnt = 0;
		reset_n = 1'b0;
		cpu_addr = '0;
		cpu_wdata = 8'h00;
		cpu_wr = 1'b0;
		cpu_bit_wr = 1'b0;
		cpu_bit_idx = 3'h0;
		cpu_rd = 1'b0;
		arb_lost_in = 1'b0;
		tx_bit_in = 1'b1;
		repeat (2) @(posedge link_clk);
		@(posedge core_clk) #1;
		reset_n = 1'b1;
		`CHK({sda_out, sda_oe_n, start_gen_req}, 3'b110)
		rd(FLAGS_ADDR, 8'h00);
		rd(STATUS_ADDR, 8'h00);
		rd(20'h00000, 8'h00);
		done("reset");
		wr(FLAGS_ADDR, 8'hFF);
		rd(FLAGS_ADDR, 8'h00);
		wr(CTL0_ADDR, 8'h80);
		rd(FLAGS_ADDR, 8'h03);
		wr(FLAGS_ADDR, 8'h00);
		rd(FLAGS_ADDR, 8'h03);
		done("options");
		wr(CTL0_ADDR, 8'h82);
		wait_gen(1);
		rd(CTL0_ADDR, 8'h80);
		done("free start");
		bm.do_start();
		settle();
		rd(STATUS_ADDR, 8'h02);
		rd(FLAGS_ADDR, 8'h41);
		wr(CTL0_ADDR, 8'h82);
		wait_gen(1);
		rd(FLAGS_ADDR, 8'hC1);
		rd(CTL0_ADDR, 8'h80);
		done("refused start");
		bm.do_byte(8'h01);
		settle();
		rd(STATUS_ADDR, 8'h0A);
		`CHK(sda_oe_n, 1'b0)
		@(posedge core_clk) #1;
		tx_bit_in = 1'b0;
		@(posedge core_clk) #1;
		`CHK(sda_out, 1'b0)
		tx_bit_in = 1'b1;
		wr(CTL0_ADDR, 8'hA0); // software would write the shift register
		rd(STATUS_ADDR, 8'h02);
		`CHK({sda_out, sda_oe_n}, 2'b11)
		bm.do_bit(1'b1);
		settle();
		rd(STATUS_ADDR, 8'h00);
		done("address byte");
		bm.do_stop();
		settle();
		rd(STATUS_ADDR, 8'h01);
		rd(FLAGS_ADDR, 8'h81);
		wr(CTL0_ADDR, 8'h82);
		wait_gen(2);
		rd(FLAGS_ADDR, 8'h01);
		done("stop");
		bm.do_start();
		settle();
		rd(STATUS_ADDR, 8'h03);
		bm.do_bit(1'b1);
		settle();
		rd(STATUS_ADDR, 8'h02);
		wr(CTL0_ADDR, 8'hC0);
		rd(STATUS_ADDR, 8'h00);
		bm.do_stop();
		settle();
		rd(STATUS_ADDR, 8'h01);
		wr(CTL1_ADDR, 8'h80);
		rd(CTL1_ADDR, 8'h80);
		wr(CTL1_ADDR, 8'h00);
		rd(STATUS_ADDR, 8'h00);
		done("leave and wake");
		@(posedge core_clk) #1;
		arb_lost_in = 1'b1;
		@(posedge core_clk) #1;
		arb_lost_in = 1'b0;
		rd(STATUS_ADDR, 8'h10);
		bwr(STATUS_ADDR, 3'(STS_ALD), 1'b0);
		rd(STATUS_ADDR, 8'h10);
		bwr(STATUS_ADDR, 3'(STS_SPD), 1'b0);
		rd(STATUS_ADDR, 8'h00);
		done("arbitration");
		bm.do_start();
		bm.do_stop();
		settle();
		rd(STATUS_ADDR, 8'h01);
		wr(CTL0_ADDR, 8'h00);
		rd(STATUS_ADDR, 8'h00);
		wr(FLAGS_ADDR, 8'h00);
		wr(CTL0_ADDR, 8'h80);
		rd(FLAGS_ADDR, 8'h40);
		wr(CTL0_ADDR, 8'h82);
		wait_gen(2);
		rd(FLAGS_ADDR, 8'h40);
		bm.do_start();
		bm.do_stop();
		settle();
		wait_gen(3);
		rd(FLAGS_ADDR, 8'h00);
		done("reservation");
		end_sim();
	end
endmodule
`default_nettype wire
